// ===== tof_pkg.sv
/*
 * Package for the tap, orientation and flat configuration bank.
 * Holds register offsets, field positions, reset values, timing constants
 * and the packed carriers shared by the bank and its users.
 * Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none
package tof_pkg;

    // Clock rate in kHz, used to turn milliseconds into cycles.
    localparam int unsigned CLK_KHZ = 10000;

    // Word indices of the bank; byte address is four times the index.
    localparam logic [7:0] IDX_TAP_TIMING   = 8'h2A;
    localparam logic [7:0] IDX_TAP_SAMP_TH  = 8'h2B;
    localparam logic [7:0] IDX_ORIENT_CFG   = 8'h2C;
    localparam logic [7:0] IDX_ORIENT_ANGLE = 8'h2D;
    localparam logic [7:0] IDX_FLAT_ANGLE   = 8'h2E;
    localparam logic [7:0] IDX_FLAT_HOLD    = 8'h2F;
    localparam logic [7:0] IDX_GRANGE       = 8'h40;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'h41;
    localparam logic [7:0] IDX_IRQ_MASK     = 8'h42;

    // Reset values of the configuration registers.
    localparam logic [7:0] RST_TAP_TIMING   = 8'h04;
    localparam logic [7:0] RST_TAP_SAMP_TH  = 8'h0A;
    localparam logic [7:0] RST_ORIENT_CFG   = 8'h18;
    localparam logic [7:0] RST_ORIENT_ANGLE = 8'h48;
    localparam logic [7:0] RST_FLAT_ANGLE   = 8'h08;
    localparam logic [7:0] RST_FLAT_HOLD    = 8'h11;
    localparam logic [1:0] RST_GRANGE       = 2'h0;

    // Writable bit masks; reserved bits read as zero.
    localparam logic [7:0] WM_TAP_TIMING    = 8'hC7;
    localparam logic [7:0] WM_TAP_SAMP_TH   = 8'hDF;
    localparam logic [7:0] WM_ORIENT_CFG    = 8'h7F;
    localparam logic [7:0] WM_ORIENT_ANGLE  = 8'h7F;
    localparam logic [7:0] WM_FLAT_ANGLE    = 8'h3F;
    localparam logic [7:0] WM_FLAT_HOLD     = 8'h37;

    // Interrupt status bits: a configuration change per group.
    localparam int unsigned IRQ_TAP    = 0;
    localparam int unsigned IRQ_ORIENT = 1;
    localparam int unsigned IRQ_FLAT   = 2;
    localparam int unsigned IRQ_W      = 3;

    // Time figures in ms and cycles.
    localparam int unsigned QUIET0_MS = 30;
    localparam int unsigned QUIET1_MS = 20;
    localparam int unsigned SHOCK0_MS = 50;
    localparam int unsigned SHOCK1_MS = 75;
    localparam int unsigned STABLE_MS = 100;
    localparam int unsigned QUIET0_CYC = QUIET0_MS * CLK_KHZ;
    localparam int unsigned QUIET1_CYC = QUIET1_MS * CLK_KHZ;
    localparam int unsigned SHOCK0_CYC = SHOCK0_MS * CLK_KHZ;
    localparam int unsigned SHOCK1_CYC = SHOCK1_MS * CLK_KHZ;
    localparam int unsigned STABLE_CYC = STABLE_MS * CLK_KHZ;

    // Double-tap window lengths in ms, indexed by the three-bit code.
    localparam logic [9:0] DWIN_MS [8] = '{10'd50, 10'd100, 10'd150,
        10'd200, 10'd250, 10'd375, 10'd500, 10'd700};

    // Flat hold times in ms, indexed by the two-bit code.
    localparam logic [11:0] HOLD_MS [4] = '{12'd0, 12'd512, 12'd1024,
        12'd2048};

    // Threshold step sizes in micro-g per g-range code.
    localparam logic [19:0] KNOCK_STEP_UG [4] = '{20'd62500, 20'd125000,
        20'd250000, 20'd500000};
    localparam logic [19:0] ORIENT_HYST_STEP_UG = 20'd62500;
    localparam logic [19:0] SLOPE_02G_UG        = 20'd200000;
    localparam logic [19:0] SLOPE_04G_UG        = 20'd400000;
    localparam logic [20:0] ACC_15G_UG          = 21'd1500000;

    // Orientation blocking modes.
    typedef enum logic [1:0] {
        TOF_BLK_NONE  = 2'h0,
        TOF_BLK_THETA = 2'h1,
        TOF_BLK_SLP02 = 2'h2,
        TOF_BLK_SLP04 = 2'h3
    } tof_block_t;

    // Orientation switching threshold modes.
    typedef enum logic [1:0] {
        TOF_OM_SYM   = 2'h0,
        TOF_OM_HIASY = 2'h1,
        TOF_OM_LOASY = 2'h2,
        TOF_OM_SYM2  = 2'h3
    } tof_omode_t;

    // Decoded settings toward the tap engine.
    typedef struct packed {
        logic [23:0] quiet_cyc;
        logic [23:0] shock_cyc;
        logic [9:0]  dwin_ms;
        logic [4:0]  samples;
        logic [4:0]  knock_threshold;
        logic [24:0] knock_thr_ug;
    } tof_tap_cfg_t;

    // Decoded settings toward the orientation engine.
    typedef struct packed {
        logic [19:0] hyst_ug;
        tof_block_t  blocking;
        logic        blk_theta;
        logic        blk_acc;
        logic [19:0] blk_slope_ug;
        logic        blk_stable;
        logic [23:0] stable_cyc;
        logic        sym;
        logic        hi_asym;
        logic        lo_asym;
        logic        updown_change_irq_en;
        logic [5:0]  theta;
    } tof_orient_cfg_t;

    // Decoded settings toward the flat engine.
    typedef struct packed {
        logic [5:0]  theta;
        logic [11:0] hold_ms;
        logic [2:0]  level_hysteresis;
        logic [3:0]  change_margin;
    } tof_flat_cfg_t;

endpackage
`default_nettype wire

// ===== tof_bank.sv
/*
 * Tap, orientation and flat configuration bank with Avalon-MM slave,
 * decoded settings for the detection engines and a change interrupt.
 * Assumes one 10 MHz clock, an asynchronous active-low reset and a bus
 * master that holds its request until waitrequest is seen low.
 */
// How it works
// - Quiet bit picks 30 ms or 20 ms
// - Shock bit picks 50 ms or 75 ms
// - Window code maps to eight durations
// - Sample code selects 2, 4, 8, 16 samples
// - Knock threshold step scales with g-range
// - Orientation hysteresis is 62.5 mg per step
// - Blocking codes 00, 01, 10 conditions
// - Code 11 adds 0.4 g slope, 100 ms stability
// - Mode code selects symmetric or asymmetric thresholds
// - Up/down change raises interrupt when enabled
// - Six-bit theta blocking angle exported
// - Six-bit flat threshold angle exported
// - Flat hold code maps to 0-2048 ms
// - Flat change needs twice the hysteresis
`timescale 1ns/1ps
`default_nettype none
module tof_bank (
    // Clock, reset and enable.
    input  wire logic                    clk_in,
    input  wire logic                    reset_n_in,
    input  wire logic                    clk_en_in,
    // Avalon-MM slave.
    input  wire logic [9:0]              avs_address_in,
    input  wire logic                    avs_read_in,
    input  wire logic                    avs_write_in,
    input  wire logic [31:0]             avs_writedata_in,
    input  wire logic [3:0]              avs_byteenable_in,
    output var  logic [31:0]             avs_readdata_out,
    output var  logic                    avs_waitrequest_out,
    output var  logic [1:0]              avs_response_out,
    // Decoded settings for the engines.
    output var  tof_pkg::tof_tap_cfg_t    tap_cfg_out,
    output var  tof_pkg::tof_orient_cfg_t orient_cfg_out,
    output var  tof_pkg::tof_flat_cfg_t   flat_cfg_out,
    // Interrupt.
    output var  logic                    irq_out
);

    // Bus handshake states, Gray coded; bit 0 is the wait request.
    typedef enum logic [1:0] {
        TOF_ST_IDLE = 2'b01,
        TOF_ST_ACK  = 2'b00
    } tof_bus_st_t;

    // Whole state of the bank.
    typedef struct packed {
        tof_bus_st_t              st;
        logic [31:0]              rdata;
        logic [1:0]               resp;
        logic [7:0]               tap_timing;
        logic [7:0]               tap_samp_th;
        logic [7:0]               orient_cfg;
        logic [7:0]               orient_angle;
        logic [7:0]               flat_angle;
        logic [7:0]               flat_hold;
        logic [1:0]               grange;
        logic [tof_pkg::IRQ_W-1:0] irq_stat;
        logic [tof_pkg::IRQ_W-1:0] irq_mask;
        logic                     irq;
        tof_pkg::tof_tap_cfg_t    tap;
        tof_pkg::tof_orient_cfg_t orient;
        tof_pkg::tof_flat_cfg_t   flat;
    } tof_state_t;

    tof_state_t s_q;
    tof_state_t s_d;
    logic       rst_meta_q;
    logic       rst_sync_n_q;

    // Reset release through two flip-flops.
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_meta_q   <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q   <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    // Reset value of the whole state.
    function automatic tof_state_t reset_state();
        tof_state_t r;
        r              = '0;
        r.st           = TOF_ST_IDLE;
        r.tap_timing   = tof_pkg::RST_TAP_TIMING;
        r.tap_samp_th  = tof_pkg::RST_TAP_SAMP_TH;
        r.orient_cfg   = tof_pkg::RST_ORIENT_CFG;
        r.orient_angle = tof_pkg::RST_ORIENT_ANGLE;
        r.flat_angle   = tof_pkg::RST_FLAT_ANGLE;
        r.flat_hold    = tof_pkg::RST_FLAT_HOLD;
        r.grange       = tof_pkg::RST_GRANGE;
        return r;
    endfunction

    // Applies a byte-lane write under the writable mask.
    function automatic logic [7:0] wr8(input logic [7:0] old,
                                       input logic [7:0] nw,
                                       input logic [7:0] msk);
        return (old & ~msk) | (nw & msk);
    endfunction

    logic [7:0]  idx;
    logic        hit;
    logic [31:0] rd;
    logic [7:0]  wd;
    logic        wr_go;
    logic        rd_go;
    logic [tof_pkg::IRQ_W-1:0] ev;
    logic [tof_pkg::IRQ_W-1:0] clr;
    logic [2:0]  blk;
    logic [4:0]  thr;

    // Next-state logic: bus slave, registers, decode and interrupts.
    always_comb
    begin
        s_d   = s_q;
        idx   = avs_address_in[9:2];
        wd    = avs_writedata_in[7:0];
        wr_go = avs_write_in && s_q.st == TOF_ST_ACK;
        rd_go = (avs_read_in || avs_write_in) && s_q.st == TOF_ST_IDLE;
        ev    = '0;
        clr   = '0;
        hit   = 1'b1;
        rd    = '0;
        blk   = '0;
        thr   = '0;
        unique case (idx)
            tof_pkg::IDX_TAP_TIMING:   rd[7:0] = s_q.tap_timing;
            tof_pkg::IDX_TAP_SAMP_TH:  rd[7:0] = s_q.tap_samp_th;
            tof_pkg::IDX_ORIENT_CFG:   rd[7:0] = s_q.orient_cfg;
            tof_pkg::IDX_ORIENT_ANGLE: rd[7:0] = s_q.orient_angle;
            tof_pkg::IDX_FLAT_ANGLE:   rd[7:0] = s_q.flat_angle;
            tof_pkg::IDX_FLAT_HOLD:    rd[7:0] = s_q.flat_hold;
            tof_pkg::IDX_GRANGE:       rd[1:0] = s_q.grange;
            tof_pkg::IDX_IRQ_STATUS:   rd[2:0] = s_q.irq_stat;
            tof_pkg::IDX_IRQ_MASK:     rd[2:0] = s_q.irq_mask;
            default:                   hit     = 1'b0;
        endcase
        // Handshake: one wait cycle, then acknowledge for one cycle.
        unique case (s_q.st)
            TOF_ST_IDLE:
            begin
                if (rd_go)
                begin
                    s_d.st    = TOF_ST_ACK;
                    s_d.rdata = avs_read_in ? rd : 32'h0000_0000;
                    s_d.resp  = hit ? 2'h0 : 2'h2;
                end
            end
            TOF_ST_ACK:
            begin
                s_d.st = TOF_ST_IDLE;
            end
            default:
            begin
                s_d.st = TOF_ST_IDLE;
            end
        endcase
        // Writes take effect at the edge where waitrequest is low.
        if (wr_go && avs_byteenable_in[0])
        begin
            unique case (idx)
                tof_pkg::IDX_TAP_TIMING:
                begin
                    s_d.tap_timing = wr8(s_q.tap_timing, wd,
                                         tof_pkg::WM_TAP_TIMING);
                    ev[tof_pkg::IRQ_TAP] = 1'b1;
                end
                tof_pkg::IDX_TAP_SAMP_TH:
                begin
                    s_d.tap_samp_th = wr8(s_q.tap_samp_th, wd,
                                          tof_pkg::WM_TAP_SAMP_TH);
                    ev[tof_pkg::IRQ_TAP] = 1'b1;
                end
                tof_pkg::IDX_ORIENT_CFG:
                begin
                    s_d.orient_cfg = wr8(s_q.orient_cfg, wd,
                                         tof_pkg::WM_ORIENT_CFG);
                    ev[tof_pkg::IRQ_ORIENT] = 1'b1;
                end
                tof_pkg::IDX_ORIENT_ANGLE:
                begin
                    s_d.orient_angle = wr8(s_q.orient_angle, wd,
                                           tof_pkg::WM_ORIENT_ANGLE);
                    ev[tof_pkg::IRQ_ORIENT] = 1'b1;
                end
                tof_pkg::IDX_FLAT_ANGLE:
                begin
                    s_d.flat_angle = wr8(s_q.flat_angle, wd,
                                         tof_pkg::WM_FLAT_ANGLE);
                    ev[tof_pkg::IRQ_FLAT] = 1'b1;
                end
                tof_pkg::IDX_FLAT_HOLD:
                begin
                    s_d.flat_hold = wr8(s_q.flat_hold, wd,
                                        tof_pkg::WM_FLAT_HOLD);
                    ev[tof_pkg::IRQ_FLAT] = 1'b1;
                end
                tof_pkg::IDX_GRANGE:
                begin
                    s_d.grange = wd[1:0];
                    ev[tof_pkg::IRQ_TAP] = 1'b1;
                end
                tof_pkg::IDX_IRQ_STATUS: clr = wd[2:0];
                tof_pkg::IDX_IRQ_MASK:   s_d.irq_mask = wd[2:0];
                default:                 clr = '0;
            endcase
        end
        // Sticky status: a new event wins over a clear in the same cycle.
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

        // Tap timing decode.
        s_d.tap.quiet_cyc = s_d.tap_timing[7] ?
            24'(tof_pkg::QUIET1_CYC) : 24'(tof_pkg::QUIET0_CYC);
        s_d.tap.shock_cyc = s_d.tap_timing[6] ?
            24'(tof_pkg::SHOCK1_CYC) : 24'(tof_pkg::SHOCK0_CYC);
        s_d.tap.dwin_ms = tof_pkg::DWIN_MS[s_d.tap_timing[2:0]];
        s_d.tap.samples = 5'(5'h02 << s_d.tap_samp_th[7:6]);
        thr = s_d.tap_samp_th[4:0];
        s_d.tap.knock_threshold = thr;
        s_d.tap.knock_thr_ug = 25'(thr) *
            25'(tof_pkg::KNOCK_STEP_UG[s_d.grange]);

        // Orientation decode.
        s_d.orient.hyst_ug = 20'(s_d.orient_cfg[6:4] *
            tof_pkg::ORIENT_HYST_STEP_UG);
        s_d.orient.blocking = tof_pkg::tof_block_t'(s_d.orient_cfg[3:2]);
        blk[0] = s_d.orient_cfg[3:2] != 2'h0;
        blk[1] = s_d.orient_cfg[3:2] == 2'h2;
        blk[2] = s_d.orient_cfg[3:2] == 2'h3;
        s_d.orient.blk_theta = blk[0];
        s_d.orient.blk_acc   = blk[0];
        s_d.orient.blk_slope_ug = blk[2] ? tof_pkg::SLOPE_04G_UG :
            (blk[1] ? tof_pkg::SLOPE_02G_UG : 20'h00000);
        s_d.orient.blk_stable = blk[2];
        s_d.orient.stable_cyc = 24'(tof_pkg::STABLE_CYC);
        s_d.orient.sym = s_d.orient_cfg[1:0] == 2'h0 ||
            s_d.orient_cfg[1:0] == 2'h3;
        s_d.orient.hi_asym = s_d.orient_cfg[1:0] == 2'h1;
        s_d.orient.lo_asym = s_d.orient_cfg[1:0] == 2'h2;
        s_d.orient.updown_change_irq_en = s_d.orient_angle[6];
        s_d.orient.theta = s_d.orient_angle[5:0];

        // Flat decode.
        s_d.flat.theta = s_d.flat_angle[5:0];
        s_d.flat.hold_ms = tof_pkg::HOLD_MS[s_d.flat_hold[5:4]];
        s_d.flat.level_hysteresis = s_d.flat_hold[2:0];
        s_d.flat.change_margin = {s_d.flat_hold[2:0], 1'b0};
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk_in or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            s_q <= reset_state();
        end
        else if (clk_en_in)
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign avs_readdata_out    = s_q.rdata;
    assign avs_waitrequest_out = s_q.st[0];
    assign avs_response_out    = s_q.resp;
    assign tap_cfg_out         = s_q.tap;
    assign orient_cfg_out      = s_q.orient;
    assign flat_cfg_out        = s_q.flat;
    assign irq_out             = s_q.irq;

endmodule
`default_nettype wire

// ===== tof_bank_properties.sv
/* Checker for the bank's decoded settings and bus answer.
   Assumes a bind onto tof_bank. */
`timescale 1ns/1ps
`default_nettype none
module tof_bank_properties (
    // Clock and reset.
    input  wire logic                     clk_in,
    input  wire logic                     reset_n_in,
    // Avalon-MM slave.
    input  wire logic [9:0]               avs_address_in,
    input  wire logic                     avs_read_in,
    input  wire logic                     avs_write_in,
    input  wire logic [31:0]              avs_writedata_in,
    input  wire logic [3:0]               avs_byteenable_in,
    input  wire logic                     avs_waitrequest_out,
    // Decoded settings.
    input  wire tof_pkg::tof_tap_cfg_t    tap_cfg_out,
    input  wire tof_pkg::tof_orient_cfg_t orient_cfg_out,
    input  wire tof_pkg::tof_flat_cfg_t   flat_cfg_out
);
    // Accepted lane-0 write, its word index and, one edge later, its byte.
    logic       wack;
    logic [7:0] idx;
    logic [7:0] wd;
    assign wack = avs_write_in && !avs_waitrequest_out
                  && avs_byteenable_in[0];
    assign idx = avs_address_in[9:2];
    always_ff @(posedge clk_in) wd <= avs_writedata_in[7:0];

    // Checks pause while reset is low.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    property p_tapt;
        wack && idx == 8'h2A |=>
            tap_cfg_out.quiet_cyc == (wd[7] ? 24'h30D40 : 24'h493E0)
            && tap_cfg_out.shock_cyc == (wd[6] ? 24'hB71B0 : 24'h7A120);
    endproperty
    a_tapt: assert property (p_tapt)
        else $error("tap timing wrong");

    property p_dwin;
        wack && idx == 8'h2A |=>
            tap_cfg_out.dwin_ms == tof_pkg::DWIN_MS[wd[2:0]];
    endproperty
    a_dwin: assert property (p_dwin)
        else $error("double window wrong");

    property p_samp;
        wack && idx == 8'h2B |=> tap_cfg_out.samples == (5'h02 << wd[7:6])
            && tap_cfg_out.knock_threshold == wd[4:0];
    endproperty
    a_samp: assert property (p_samp)
        else $error("tap samples wrong");

    property p_knock;
        wack && idx == 8'h40 |=> tap_cfg_out.knock_thr_ug ==
            (25'(tap_cfg_out.knock_threshold) * 25'hF424) << wd[1:0];
    endproperty
    a_knock: assert property (p_knock)
        else $error("threshold scaling wrong");

    property p_orient;
        wack && idx == 8'h2C |=>
            orient_cfg_out.hyst_ug == 20'(wd[6:4]) * 20'hF424
            && orient_cfg_out.blocking == wd[3:2]
            && orient_cfg_out.stable_cyc == 24'hF4240
            && orient_cfg_out.blk_stable == (wd[3:2] == 2'h3)
            && orient_cfg_out.sym == (wd[1] == wd[0]);
    endproperty
    a_orient: assert property (p_orient)
        else $error("orient settings wrong");

    property p_updown;
        wack && idx == 8'h2D |=> orient_cfg_out.theta == wd[5:0]
            && orient_cfg_out.updown_change_irq_en == wd[6];
    endproperty
    a_updown: assert property (p_updown)
        else $error("orient angle wrong");

    property p_flat;
        wack && idx == 8'h2F |=> flat_cfg_out.change_margin == {wd[2:0], 1'b0}
            && flat_cfg_out.level_hysteresis == wd[2:0]
            && flat_cfg_out.hold_ms ==
            (wd[5:4] == 2'h0 ? 12'h000 : 12'h100 << wd[5:4]);
    endproperty
    a_flat: assert property (p_flat)
        else $error("flat settings wrong");

    property p_ack;
        $rose(avs_read_in || avs_write_in) |=>
            !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer late");
endmodule
`default_nettype wire

// ===== tof_host.sv
/* Host model that programs the bank as an Avalon-MM master.
   Assumes the bench calls xfer from one process at a time. */
`timescale 1ns/1ps
`default_nettype none
module tof_host (
    // Clock.
    input  wire logic        clk_in,
    // Avalon-MM master signals.
    output var  logic [9:0]  address_out,
    output var  logic        read_out,
    output var  logic        write_out,
    output var  logic [31:0] writedata_out,
    output var  logic [3:0]  byteenable_out,
    input  wire logic [31:0] readdata_in,
    input  wire logic        waitrequest_in,
    input  wire logic [1:0]  response_in
);
    // The bus is idle from time zero.
    initial
    begin
        address_out = 10'h000;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = 32'h0;
        byteenable_out = 4'h0;
    end

    // Request held until waitrequest is sampled low; on release address
    // and write data are inverted so stale values cannot pass for data.
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [7:0] wd, input logic [3:0] be,
                        output logic [31:0] rd, output logic [1:0] rsp);
        @(posedge clk_in);
        address_out <= {idx, 2'b00};
        read_out <= !wr;
        write_out <= wr;
        writedata_out <= {24'h0, wd};
        byteenable_out <= be;
        do
            @(posedge clk_in);
        while (waitrequest_in !== 1'b0);
        rd = readdata_in;
        rsp = response_in;
        read_out <= 1'b0;
        write_out <= 1'b0;
        address_out <= ~address_out;
        writedata_out <= ~writedata_out;
    endtask
endmodule
`default_nettype wire

// ===== tof_bank_tb.sv
/* Self-checking bench for the configuration bank.
   Assumes package, bank, host model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tof_bank_tb;
    // Clock, reset, bus wires and bookkeeping.
    logic                     clk_in = 1'b0;
    logic                     reset_n_in;
    logic                     clk_en_in;
    logic [9:0]               adr;
    logic                     rdq;
    logic                     wrq;
    logic [31:0]              wdat;
    logic [3:0]               be;
    logic [31:0]              rdat;
    logic                     wait_r;
    logic [1:0]               resp;
    tof_pkg::tof_tap_cfg_t    tap;
    tof_pkg::tof_orient_cfg_t ori;
    tof_pkg::tof_flat_cfg_t   flat;
    logic                     irq;
    logic [31:0]              d;
    logic [1:0]               r;
    int                       error_cnt = 0;
    int                       checks_done = 0;
    int                       cycles = 0;

    // Free-running 10 MHz clock.
    always #50 clk_in = ~clk_in;

    // Host model and the bank under test.
    tof_host host (.clk_in(clk_in), .address_out(adr), .read_out(rdq),
        .write_out(wrq), .writedata_out(wdat), .byteenable_out(be),
        .readdata_in(rdat), .waitrequest_in(wait_r), .response_in(resp));
    tof_bank dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in), .avs_address_in(adr), .avs_read_in(rdq),
        .avs_write_in(wrq), .avs_writedata_in(wdat),
        .avs_byteenable_in(be), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wait_r), .avs_response_out(resp),
        .tap_cfg_out(tap), .orient_cfg_out(ori), .flat_cfg_out(flat),
        .irq_out(irq));

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Writes one register and checks the answer.
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        host.xfer(1'b1, i, v, 4'h1, d, r);
        chk("write response", 32'h0, 32'(r));
        #1;
    endtask

    // Reads one register, checks data and answer.
    task automatic rdc(input logic [7:0] i, input logic [31:0] e,
                       input string nm);
        host.xfer(1'b0, i, 8'h00, 4'h1, d, r);
        chk(nm, e, d);
        chk("read response", 32'h0, 32'(r));
    endtask

    // Reset values, then all ones and zeros; reserved bits stay zero.
    task automatic t_regs();
        logic [7:0] rv [6] = '{8'h04, 8'h0A, 8'h18, 8'h48, 8'h08, 8'h11};
        logic [7:0] wm [6] = '{8'hC7, 8'hDF, 8'h7F, 8'h7F, 8'h3F, 8'h37};
        rdc(8'h40, 32'h0, "range reset");
        rdc(8'h42, 32'h0, "mask reset");
        chk("reset window", 32'h0FA, 32'(tap.dwin_ms));
        for (int k = 0; k < 6; k++)
        begin
            rdc(8'h2A + 8'(k), 32'(rv[k]), "reset");
            wr(8'h2A + 8'(k), 8'hFF);
            rdc(8'h2A + 8'(k), 32'(wm[k]), "ones");
            wr(8'h2A + 8'(k), 8'h00);
            rdc(8'h2A + 8'(k), 32'h0, "zeros");
        end
        host.xfer(1'b1, 8'h2A, 8'hFF, 4'hE, d, r);
        rdc(8'h2A, 32'h0, "lane 0 off");
    endtask

    // Every tap timing, sample and range code.
    task automatic t_tap();
        logic [9:0] wl [8] = '{10'h032, 10'h064, 10'h096, 10'h0C8,
                               10'h0FA, 10'h177, 10'h1F4, 10'h2BC};
        for (int k = 0; k < 8; k++)
        begin
            wr(8'h2A, {k[0], k[1], 3'h0, k[2:0]});
            chk("quiet", k[0] ? 32'h30D40 : 32'h493E0,
                32'(tap.quiet_cyc));
            chk("shock", k[1] ? 32'hB71B0 : 32'h7A120,
                32'(tap.shock_cyc));
            chk("window", 32'(wl[k]), 32'(tap.dwin_ms));
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h2B, {k[1:0], 6'h1F});
            chk("samples", 32'h2 << k, 32'(tap.samples));
            wr(8'h40, 8'(k));
            chk("scaled threshold", 32'h1D905C << k,
                32'(tap.knock_thr_ug));
        end
        wr(8'h2B, 8'h01);
        chk("range scale", 32'h7A120, 32'(tap.knock_thr_ug));
    endtask

    // Orientation and flat codes: every blocking, mode and hold code; odd hysteresis codes and four angles only.
    task automatic t_orient();
        logic [31:0] sl [4] = '{32'h0, 32'h0, 32'h30D40, 32'h61A80};
        logic [31:0] hl [4] = '{32'h0, 32'h200, 32'h400, 32'h800};
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h2C, {1'b0, 3'(2 * k + 1), k[1:0], k[1:0]});
            chk("hyst", (2 * k + 1) * 32'hF424, 32'(ori.hyst_ug));
            chk("slope", sl[k], 32'(ori.blk_slope_ug));
            chk("block flags", 32'({k != 0, k != 0, k == 3}),
                32'({ori.blk_theta, ori.blk_acc, ori.blk_stable}));
            chk("mode flags", 32'({k == 0 || k == 3, k == 1, k == 2}),
                32'({ori.sym, ori.hi_asym, ori.lo_asym}));
            wr(8'h2D, {1'b0, k[0], 6'(21 * k)});
            chk("updown", 32'(k[0]), 32'(ori.updown_change_irq_en));
            chk("block angle", 32'(21 * k), 32'(ori.theta));
            wr(8'h2E, 8'(21 * k));
            chk("flat angle", 32'(21 * k), 32'(flat.theta));
            wr(8'h2F, {2'h0, k[1:0], 1'b0, 3'(2 * k + 1)});
            chk("hold", hl[k], 32'(flat.hold_ms));
            chk("margin", 32'(4 * k + 2), 32'(flat.change_margin));
        end
    endtask

    // Sticky status, mask gating, clear by one; unmapped word errors.
    task automatic t_irq();
        wr(8'h42, 8'h00);
        rdc(8'h41, 32'h7, "status");
        chk("masked irq", 32'h0, 32'(irq));
        wr(8'h42, 8'h07);
        chk("unmasked irq", 32'h1, 32'(irq));
        wr(8'h41, 8'h03);
        wr(8'h42, 8'h03);
        rdc(8'h41, 32'h4, "status after clear");
        chk("flat masked", 32'h0, 32'(irq));
        wr(8'h41, 8'h04);
        wr(8'h2E, 8'h08);
        wr(8'h42, 8'h04);
        chk("flat irq", 32'h1, 32'(irq));
        wr(8'h41, 8'h04);
        chk("irq cleared", 32'h0, 32'(irq));
        host.xfer(1'b1, 8'h10, 8'hFF, 4'h1, d, r);
        chk("unmapped write", 32'h2, 32'(r));
        host.xfer(1'b0, 8'h10, 8'h00, 4'h1, d, r);
        chk("unmapped read", 32'h2, 32'(r));
        chk("unmapped data", 32'h0, d);
    endtask

    // Prints counts and verdict, then ends the run.
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // A hang past the ceiling counts as a mismatch.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    // Reset for 8 cycles, then each scenario.
    initial
    begin
        reset_n_in = 1'b0;
        clk_en_in = 1'b1;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_regs();
        t_tap();
        t_orient();
        t_irq();
        give_verdict();
    end
endmodule

bind tof_bank tof_bank_properties chk_i (.clk_in, .reset_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_waitrequest_out, .tap_cfg_out,
    .orient_cfg_out, .flat_cfg_out);
`default_nettype wire
